/* src/i2c_protocol_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "i2c_engine_cfg.svh"
module i2c_protocol_engine #(
  parameter int HALF_CYCLES = `SCL_HALF_CYC
) (
  // clocks and reset
  input wire logic CLK_SYS_IN,
  input wire logic LINK_CLK_IN,
  input wire logic RST_N_IN,
  // configuration levels
  input wire logic [2:0] FUNC_MODE_IN,
  input wire logic [1:0] SAMPLE_CLK_SEL_IN,
  input wire logic [6:0] OWN_ADDR_IN,
  input wire logic GC_EN_IN,
  input wire logic [15:0] INT_ENABLE_IN,
  // protocol control
  input wire logic START_REQ_IN,
  input wire logic STOP_REQ_IN,
  input wire logic ASSERT_ACK_IN,
  input wire logic TRIGGER_IN,
  input wire logic [7:0] TX_DATA_IN,
  input wire logic TX_WRITE_IN,
  input wire logic [15:0] STATUS_CLEAR_IN,
  // status
  output logic [15:0] PROTOCOL_STATUS_OUT,
  output logic PROTOCOL_INT_OUT,
  output logic CMD_PENDING_OUT,
  output logic [7:0] RX_DATA_OUT,
  // bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE_OUT,
  output logic SDA_OUT,
  output logic SDA_OE_OUT
);
  import i2c_engine_pkg::*;

  // ----------------------------------------------------------------
  // system domain state
  // ----------------------------------------------------------------
  logic [15:0] status, next_status; // sticky flags, low byte zero
  logic irq, next_irq;
  logic mode_on, next_mode_on; // engine enabled
  logic [7:0] tx_byte, next_tx_byte;
  logic tx_valid, next_tx_valid;
  logic c_start, c_stop, c_aa, c_txv; // command held for link
  logic next_c_start, next_c_stop, next_c_aa, next_c_txv;
  logic [7:0] c_byte, next_c_byte;
  logic cmd_tgl, next_cmd_tgl;
  logic pending, next_pending;
  logic [7:0] rx_data, next_rx_data;
  logic ack_s; // link acknowledge, synchronised
  event_t evt_s, evt_d; // event toggles, synchronised
  event_t evt_p; // one-cycle event pulses
  logic [7:0] ien; // enables mapped to flag order

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  link_state_e state, next_state;
  logic master, next_master;
  logic addressed, next_addressed;
  logic listen, next_listen; // address recognition on
  logic dir_tx, next_dir_tx;
  logic addr_phase, next_addr_phase;
  logic ack_drive, next_ack_drive;
  logic ack_in, next_ack_in;
  logic [7:0] shift, next_shift;
  logic [3:0] bitcnt, next_bitcnt;
  logic [11:0] cnt, next_cnt;
  logic scl_low, next_scl_low; // pull clock line low
  logic sda_low, next_sda_low; // pull data line low
  logic busy, next_busy; // bus taken by any master
  logic req_seen, next_req_seen; // doubles as acknowledge toggle
  event_t evt_tgl, next_evt_tgl;
  logic [7:0] rx_byte, next_rx_byte;
  logic scl_d, sda_d; // previous synced pin levels
  logic scl_s, sda_s, req_s, en_s;
  logic gc_s;
  logic [6:0] addr_s;
  logic [1:0] pins_s;
  logic [8:0] cfg_s;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  // pins into link domain before any logic looks at them
  cdc_sync #(.WIDTH(2)) u_pin_sync (
    .clk_in(LINK_CLK_IN), .rst_n_in(RST_N_IN), .d_in({SCL_IN, SDA_IN}), .q_out(pins_s));
  // static configuration and mode level into link domain
  cdc_sync #(.WIDTH(9)) u_cfg_sync (
    .clk_in(LINK_CLK_IN), .rst_n_in(RST_N_IN), .d_in({mode_on, GC_EN_IN, OWN_ADDR_IN}),
    .q_out(cfg_s));
  // command request toggle, data word is held stable while pending
  cdc_sync #(.WIDTH(1)) u_req_sync (
    .clk_in(LINK_CLK_IN), .rst_n_in(RST_N_IN), .d_in(cmd_tgl), .q_out(req_s));
  // acknowledge toggle back into system domain
  cdc_sync #(.WIDTH(1)) u_ack_sync (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .d_in(req_seen), .q_out(ack_s));
  // event toggles into system domain
  cdc_sync #(.WIDTH(8)) u_evt_sync (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .d_in(evt_tgl), .q_out(evt_s));

  assign {scl_s, sda_s} = pins_s;
  assign {en_s, gc_s, addr_s} = cfg_s;
  assign evt_p = evt_s ^ evt_d;
  assign ien = {INT_ENABLE_IN[`IEN_SLAVE_READ_REQUEST_FLAG], 1'b0, INT_ENABLE_IN[`IEN_ACK],
                INT_ENABLE_IN[`IEN_ERR], INT_ENABLE_IN[`IEN_ARB], INT_ENABLE_IN[`IEN_NACK],
                INT_ENABLE_IN[`IEN_STOP], INT_ENABLE_IN[`IEN_START]};

  // ----------------------------------------------------------------
  // system domain next values
  // ----------------------------------------------------------------
  always_comb begin
    next_mode_on = (FUNC_MODE_IN == `FUNC_MODE_I2C) && (SAMPLE_CLK_SEL_IN == `SAMPLE_SEL_DIV);
    // an event in the clearing cycle survives
    next_status = (status & ~STATUS_CLEAR_IN) | {evt_p, 8'h00};
    next_status[7:0] = 8'h00;
    next_irq = |(status[15:8] & ien);
    next_tx_byte = tx_byte;
    next_tx_valid = tx_valid;
    next_c_start = c_start;
    next_c_stop = c_stop;
    next_c_aa = c_aa;
    next_c_txv = c_txv;
    next_c_byte = c_byte;
    next_cmd_tgl = cmd_tgl;
    next_rx_data = rx_data;
    // a trigger while the last one is in flight is dropped
    if (TRIGGER_IN && mode_on && !pending) begin
      next_c_start = START_REQ_IN;
      next_c_stop = STOP_REQ_IN;
      next_c_aa = ASSERT_ACK_IN;
      next_c_txv = tx_valid;
      next_c_byte = tx_byte;
      next_cmd_tgl = ~cmd_tgl;
      next_tx_valid = 1'b0; // byte consumed
    end
    if (evt_p[`EV_NACK] || evt_p[`EV_ERR]) begin
      next_tx_valid = 1'b0;
    end
    if (TX_WRITE_IN) begin
      next_tx_byte = TX_DATA_IN;
      next_tx_valid = 1'b1;
    end
    // link holds the byte long after its event
    if (evt_p[`EV_ACK] || evt_p[`EV_NACK] || evt_p[`EV_SLAVE_READ_REQUEST_FLAG] || evt_p[`EV_ARB]) begin
      next_rx_data = rx_byte;
    end
    next_pending = (next_cmd_tgl != ack_s);
  end

  // system domain registers
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      status <= 16'h0000;
      irq <= 1'b0;
      mode_on <= 1'b0;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      c_start <= 1'b0;
      c_stop <= 1'b0;
      c_aa <= 1'b0;
      c_txv <= 1'b0;
      c_byte <= 8'h00;
      cmd_tgl <= 1'b0;
      pending <= 1'b0;
      rx_data <= 8'h00;
      evt_d <= 8'h00;
    end else begin
      status <= next_status;
      irq <= next_irq;
      mode_on <= next_mode_on;
      tx_byte <= next_tx_byte;
      tx_valid <= next_tx_valid;
      c_start <= next_c_start;
      c_stop <= next_c_stop;
      c_aa <= next_c_aa;
      c_txv <= next_c_txv;
      c_byte <= next_c_byte;
      cmd_tgl <= next_cmd_tgl;
      pending <= next_pending;
      rx_data <= next_rx_data;
      evt_d <= evt_s;
    end
  end

  assign PROTOCOL_STATUS_OUT = status;
  assign PROTOCOL_INT_OUT = irq;
  assign CMD_PENDING_OUT = pending;
  assign RX_DATA_OUT = rx_data;

  // ----------------------------------------------------------------
  // link domain sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic rise, fall, start_det, stop_det, new_cmd, drove_one, hit, engaged;
    event_t ev;
    rise = scl_s && !scl_d;
    fall = !scl_s && scl_d;
    start_det = scl_s && scl_d && sda_d && !sda_s;
    stop_det = scl_s && scl_d && !sda_d && sda_s;
    new_cmd = (req_s != req_seen);
    drove_one = !sda_low && (dir_tx ? (bitcnt < 4'h8) : (bitcnt == 4'h8));
    hit = (shift[7:1] == addr_s) || (gc_s && (shift[7:1] == 7'h00));
    engaged = master || addressed;
    ev = 8'h00;
    next_state = state;
    next_master = master;
    next_addressed = addressed;
    next_listen = listen;
    next_dir_tx = dir_tx;
    next_addr_phase = addr_phase;
    next_ack_drive = ack_drive;
    next_ack_in = ack_in;
    next_shift = shift;
    next_bitcnt = bitcnt;
    next_cnt = cnt;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    next_busy = busy;
    next_req_seen = req_seen;
    next_rx_byte = rx_byte;
    unique case (state)
      // idle or stretching: wait for software
      L_IDLE, L_WAIT: begin
        if (new_cmd) begin
          next_req_seen = req_s;
          next_listen = c_aa;
          next_ack_drive = c_aa;
          next_cnt = 12'h000;
          if (c_stop && master) begin
            next_state = L_STOP;
            next_sda_low = 1'b1;
          end else if (c_start) begin
            next_state = L_START;
            next_sda_low = 1'b0;
          end else if (state == L_WAIT) begin
            if (!dir_tx) begin
              next_state = L_XFER;
              next_sda_low = 1'b0;
              next_scl_low = master;
            end else if (c_txv) begin
              next_shift = c_byte;
              next_sda_low = !c_byte[7];
              next_state = L_XFER;
              next_scl_low = master;
            end
            // no valid byte: clock stays held low
          end
        end
      end
      // start or repeated start generation
      L_START: begin
        if (!sda_low) begin
          next_scl_low = 1'b0;
          if (busy && !master) begin
            next_cnt = 12'h000;
          end else if (scl_s && sda_s) begin
            next_cnt = cnt + 12'h001;
            if (cnt == 12'(HALF_CYCLES)) begin
              next_sda_low = 1'b1;
              next_master = 1'b1;
              next_cnt = 12'h000;
            end
          end else begin
            next_cnt = 12'h000;
          end
        end else begin
          next_cnt = cnt + 12'h001;
          if (cnt == 12'(HALF_CYCLES)) begin
            next_scl_low = 1'b1;
            next_state = L_WAIT;
            next_dir_tx = 1'b1;
            next_addr_phase = 1'b1;
            next_bitcnt = 4'h0;
            next_cnt = 12'h000;
          end
        end
      end
      // stop generation, data already low
      L_STOP: begin
        next_cnt = cnt + 12'h001;
        if (scl_low) begin
          if (cnt == 12'(HALF_CYCLES)) begin
            next_scl_low = 1'b0;
            next_cnt = 12'h000;
          end
        end else if (!scl_s) begin
          next_cnt = 12'h000;
        end else if (cnt == 12'(HALF_CYCLES)) begin
          next_sda_low = 1'b0;
          next_state = L_IDLE;
        end
      end
      // bit transfer, both roles follow the synced clock
      L_XFER: begin
        if (master) begin
          next_cnt = cnt + 12'h001;
          if (!scl_low && !scl_s) begin
            next_cnt = 12'h000; // someone else stretches
          end else if (cnt == 12'(HALF_CYCLES)) begin
            next_scl_low = !scl_low;
            next_cnt = 12'h000;
          end
        end
        if (rise) begin
          if (bitcnt < 4'h8) begin
            next_shift = {shift[6:0], sda_s};
          end else begin
            next_ack_in = sda_s;
          end
          next_bitcnt = bitcnt + 4'h1;
          if (master && drove_one && !sda_s) begin
            ev[`EV_ARB] = 1'b1;
            next_master = 1'b0;
            next_scl_low = 1'b0;
            next_dir_tx = 1'b0;
            if (!addr_phase) begin
              next_state = L_IDLE;
            end
          end
        end
        if (fall) begin
          if (bitcnt == 4'h8) begin
            if (dir_tx) begin
              next_sda_low = 1'b0;
            end else if (addr_phase && !master) begin
              next_addressed = hit && listen;
              next_sda_low = hit && listen;
              if (!(hit && listen)) begin
                next_state = L_IDLE;
              end
            end else begin
              next_sda_low = ack_drive;
            end
          end else if (bitcnt == 4'h9) begin
            next_rx_byte = shift;
            next_sda_low = 1'b0;
            next_bitcnt = 4'h0;
            next_addr_phase = 1'b0;
            next_state = L_WAIT;
            next_scl_low = engaged;
            if (dir_tx) begin
              ev[`EV_NACK] = ack_in;
              ev[`EV_ACK] = !ack_in;
              if (master && addr_phase) begin
                next_dir_tx = !shift[0];
              end
              if (ack_in && !master) begin
                next_addressed = 1'b0;
                next_state = L_IDLE;
                next_scl_low = 1'b0;
              end
            end else if (addr_phase) begin
              ev[`EV_SLAVE_READ_REQUEST_FLAG] = shift[0];
              ev[`EV_ACK] = !shift[0];
              next_dir_tx = shift[0];
            end else begin
              ev[`EV_ACK] = ack_drive;
              ev[`EV_NACK] = !ack_drive;
            end
          end else begin
            next_sda_low = dir_tx && !shift[7];
          end
        end
      end
    endcase
    // bus conditions override the sequencer
    if (start_det) begin
      next_busy = 1'b1;
      if (state == L_XFER && bitcnt != 4'h0 && engaged) begin
        ev[`EV_ERR] = 1'b1;
        next_state = L_IDLE;
        next_master = 1'b0;
        next_addressed = 1'b0;
        next_scl_low = 1'b0;
        next_sda_low = 1'b0;
      end else begin
        ev[`EV_START] = engaged;
        if (!master && listen) begin
          next_state = L_XFER;
          next_addressed = 1'b0;
          next_dir_tx = 1'b0;
          next_addr_phase = 1'b1;
          next_bitcnt = 4'h0;
          next_scl_low = 1'b0;
          next_sda_low = 1'b0;
        end
      end
    end
    if (stop_det) begin
      next_busy = 1'b0;
      if (state == L_XFER && bitcnt != 4'h0 && engaged) begin
        ev[`EV_ERR] = 1'b1;
      end else begin
        ev[`EV_STOP] = engaged;
      end
      next_state = L_IDLE;
      next_master = 1'b0;
      next_addressed = 1'b0;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
    end
    // mode off acts as a soft reset, pending commands dropped
    if (!en_s) begin
      next_state = L_IDLE;
      next_master = 1'b0;
      next_addressed = 1'b0;
      next_listen = 1'b0;
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      next_busy = 1'b0;
      next_req_seen = req_s;
      ev = 8'h00;
    end
    next_evt_tgl = evt_tgl ^ ev;
  end

  // link domain registers
  always_ff @(posedge LINK_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= L_IDLE;
      master <= 1'b0;
      addressed <= 1'b0;
      listen <= 1'b0;
      dir_tx <= 1'b0;
      addr_phase <= 1'b0;
      ack_drive <= 1'b0;
      ack_in <= 1'b0;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      cnt <= 12'h000;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b0;
      req_seen <= 1'b0;
      evt_tgl <= 8'h00;
      rx_byte <= 8'h00;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      state <= next_state;
      master <= next_master;
      addressed <= next_addressed;
      listen <= next_listen;
      dir_tx <= next_dir_tx;
      addr_phase <= next_addr_phase;
      ack_drive <= next_ack_drive;
      ack_in <= next_ack_in;
      shift <= next_shift;
      bitcnt <= next_bitcnt;
      cnt <= next_cnt;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
      busy <= next_busy;
      req_seen <= next_req_seen;
      evt_tgl <= next_evt_tgl;
      rx_byte <= next_rx_byte;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // open-drain: level is always low, only the enable moves
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE_OUT = scl_low;
  assign SDA_OE_OUT = sda_low;
endmodule : i2c_protocol_engine
`default_nettype wire

/* pkg/i2c_engine_cfg.svh */
// Contract
// - stall clock when nothing valid to send
// - trigger bit write ends the clock stretch
// - master drives one, reads zero: arbitration lost
// - loser may clock to byte end, then slave
// - arbitration loss sets flag, enable gates interrupt
// - lost while addressing: slave, still match address
// - after nack or error, wait new buffer write
// - proper start and stop set their flags
// - read request as slave sets its flag
// - ack and nack received set their flags
// - misplaced start or stop sets error flag
// - flags stay until software writes one
// - data and clock pins are open-drain
// - sample clock select must be zero
// - own or general address acked on ninth clock
// - master start waits for a free bus
// - control bits pick next action after trigger
`ifndef I2C_ENGINE_CFG_SVH
`define I2C_ENGINE_CFG_SVH

// ----------------------------------------------------------------
// mode and clock selection
// ----------------------------------------------------------------
`define FUNC_MODE_I2C 3'h4
`define SAMPLE_SEL_DIV 2'h0

// ----------------------------------------------------------------
// status flag positions in the protocol status word
// ----------------------------------------------------------------
`define STS_LOW 8
`define STS_START 8
`define STS_STOP 9
`define STS_NACK 10
`define STS_ARB 11
`define STS_ERR 12
`define STS_ACK 13
`define STS_SLAVE_READ_REQUEST_FLAG 15

// ----------------------------------------------------------------
// event index, status bit minus the low offset
// ----------------------------------------------------------------
`define EV_START 0
`define EV_STOP 1
`define EV_NACK 2
`define EV_ARB 3
`define EV_ERR 4
`define EV_ACK 5
`define EV_SLAVE_READ_REQUEST_FLAG 7

// ----------------------------------------------------------------
// interrupt enable positions
// ----------------------------------------------------------------
`define IEN_START 0
`define IEN_STOP 1
`define IEN_NACK 2
`define IEN_ARB 4
`define IEN_ERR 5
`define IEN_ACK 6
`define IEN_SLAVE_READ_REQUEST_FLAG 7

// ----------------------------------------------------------------
// bus timing on the link clock
// ----------------------------------------------------------------
`define SCL_HALF_NS 1250
`define LINK_CLK_PERIOD_PS 12000
`define SCL_HALF_CYC ((`SCL_HALF_NS * 1000 + `LINK_CLK_PERIOD_PS - 1) / `LINK_CLK_PERIOD_PS)

`endif

/* pkg/i2c_engine_pkg.sv */
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package i2c_engine_pkg;
  // link-side sequencer states
  typedef enum logic [2:0] {L_IDLE, L_START, L_WAIT, L_XFER, L_STOP} link_state_e;
  // one bit per protocol event, status bits 15..8
  typedef logic [7:0] event_t;
endpackage : i2c_engine_pkg

/* src/cdc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// two-stage level synchroniser
// ----------------------------------------------------------------
module cdc_sync #(
  parameter int WIDTH = 1
) (
  // destination clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta; // first stage, read only by second stage
  logic [WIDTH-1:0] stable; // second stage

  // both stages clear to zero on reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      stable <= '0;
    end else begin
      meta <= d_in;
      stable <= meta;
    end
  end

  assign q_out = stable;
endmodule : cdc_sync
`default_nettype wire

/* tb/i2c_protocol_engine_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_protocol_engine_chk
  import i2c_engine_pkg::*;
#(
  parameter int HALF_CYCLES = 4
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // control levels and pulses
  input wire logic [2:0] FUNC_MODE_IN,
  input wire logic [1:0] SAMPLE_CLK_SEL_IN,
  input wire logic [15:0] INT_ENABLE_IN,
  input wire logic TRIGGER_IN,
  input wire logic [15:0] STATUS_CLEAR_IN,
  // status and pins
  input wire logic [15:0] PROTOCOL_STATUS_OUT,
  input wire logic PROTOCOL_INT_OUT,
  input wire logic CMD_PENDING_OUT,
  input wire logic SCL_OUT,
  input wire logic SCL_OE_OUT,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_OUT
);
  // link pins are sampled on the system clock, hence loose bounds
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [15:0] st; // short alias
  logic [7:0] armed; // flags lined up with their enables
  logic any_armed;
  assign st = PROTOCOL_STATUS_OUT;
  assign armed = st[15:8] & {INT_ENABLE_IN[7], 1'b0, INT_ENABLE_IN[6:4], INT_ENABLE_IN[2:0]};
  assign any_armed = |armed;
  property p_int;
    PROTOCOL_INT_OUT == $past(any_armed);
  endproperty
  a_int: assert property (p_int) else $error("interrupt differs from enabled flags");
  property p_sticky;
    1'b1 |=> ((($past(st) & ~$past(STATUS_CLEAR_IN)) & ~st) == 16'h0000);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
  property p_rsvd;
    (st & 16'h40FF) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("unused status bit set");
  property p_od;
    SCL_OUT == 1'b0 && SDA_OUT == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin drives high");
  property p_take;
    (TRIGGER_IN && !CMD_PENDING_OUT && FUNC_MODE_IN == 3'h4 && $past(FUNC_MODE_IN) == 3'h4
      && $past(FUNC_MODE_IN, 8) == 3'h4 && SAMPLE_CLK_SEL_IN == 2'h0
      && $past(SAMPLE_CLK_SEL_IN) == 2'h0
      && $past(SAMPLE_CLK_SEL_IN, 8) == 2'h0) |=> CMD_PENDING_OUT;
  endproperty
  a_take: assert property (p_take) else $error("trigger not taken");
  property p_pend;
    $rose(CMD_PENDING_OUT) |-> ##[1:40] !CMD_PENDING_OUT;
  endproperty
  a_pend: assert property (p_pend) else $error("command stuck pending");
  property p_sel;
    (SAMPLE_CLK_SEL_IN != 2'h0 && $past(SAMPLE_CLK_SEL_IN) != 2'h0
      && $past(SAMPLE_CLK_SEL_IN, 2) != 2'h0 && TRIGGER_IN) |=> !CMD_PENDING_OUT;
  endproperty
  a_sel: assert property (p_sel) else $error("trigger taken with bad sample select");
  property p_stretch;
    $rose(st[13]) ##1 !TRIGGER_IN [*8] |-> SCL_OE_OUT;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held after byte");
  property p_arb;
    $rose(st[11]) |-> ##[1:40] (!SCL_OE_OUT && !SDA_OE_OUT);
  endproperty
  a_arb: assert property (p_arb) else $error("bus kept after lost arbitration");
endmodule : i2c_protocol_engine_chk
bind i2c_protocol_engine i2c_protocol_engine_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
  .CLK_SYS_IN, .RST_N_IN, .FUNC_MODE_IN, .SAMPLE_CLK_SEL_IN, .INT_ENABLE_IN, .TRIGGER_IN,
  .STATUS_CLEAR_IN, .PROTOCOL_STATUS_OUT, .PROTOCOL_INT_OUT, .CMD_PENDING_OUT, .SCL_OUT,
  .SCL_OE_OUT, .SDA_OUT, .SDA_OE_OUT
);
`default_nettype wire

/* tb/i2c_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_partner (
  // resolved bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // behaviour commands
  input wire logic ack_en_in,
  input wire logic hold_low_in,
  // high while pulling data low
  output logic sda_oe_out
);
  int bit_cnt = -1; // clock falls since start
  // start or stop restarts the count
  always @(sda_in) if (scl_in) bit_cnt = -1;
  // wraps after the ninth bit of each byte
  always @(negedge scl_in) bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
  // hold_low plays a winning master, only ever set while clock is low
  assign sda_oe_out = hold_low_in || (ack_en_in && bit_cnt == 8);
endmodule : i2c_bus_partner
`default_nettype wire

/* tb/i2c_protocol_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_protocol_engine_bench;
  import i2c_engine_pkg::*;
  logic clk, lclk, rst_n, trig, start_request, stop_request, txw, ack_en, hold_low;
  logic [2:0] mode;
  logic [1:0] sel;
  logic [7:0] txd, rx;
  logic [15:0] ien, clr, st;
  logic irq, pend, scl_o, scl_oe, sda_o, sda_oe, p_oe;
  wire logic scl_bus;
  wire logic sda_bus;
  int fail_count, cmp_count, cyc;
  // open-drain lines with pull-ups
  assign scl_bus = !scl_oe;
  assign sda_bus = !(sda_oe || p_oe);
  i2c_protocol_engine #(.HALF_CYCLES(4)) u_dut (
    .CLK_SYS_IN(clk), .LINK_CLK_IN(lclk), .RST_N_IN(rst_n), .FUNC_MODE_IN(mode),
    .SAMPLE_CLK_SEL_IN(sel), .OWN_ADDR_IN(7'h2A), .GC_EN_IN(1'b0), .INT_ENABLE_IN(ien),
    .START_REQ_IN(start_request), .STOP_REQ_IN(stop_request), .ASSERT_ACK_IN(1'b0), .TRIGGER_IN(trig),
    .TX_DATA_IN(txd), .TX_WRITE_IN(txw), .STATUS_CLEAR_IN(clr), .PROTOCOL_STATUS_OUT(st),
    .PROTOCOL_INT_OUT(irq), .CMD_PENDING_OUT(pend), .RX_DATA_OUT(rx), .SCL_IN(scl_bus),
    .SDA_IN(sda_bus), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_OUT(sda_o),
    .SDA_OE_OUT(sda_oe)
  );
  i2c_bus_partner u_partner (
    .scl_in(scl_bus), .sda_in(sda_bus), .ack_en_in(ack_en), .hold_low_in(hold_low),
    .sda_oe_out(p_oe)
  );
  // clocks of unrelated phase
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #6 lclk = ~lclk;
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // issue one command, then wait for the handover to finish
  task command(input logic s, input logic p);
    int n;
    n = 0;
    @(posedge clk);
    start_request <= s;
    stop_request <= p;
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    while (pend !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(pend), 16'h0000);
  endtask : command
  task load(input logic [7:0] b);
    @(posedge clk);
    txd <= b;
    txw <= 1'b1;
    @(posedge clk);
    txw <= 1'b0;
  endtask : load
  // bounded wait for flags, a full byte is about 110 cycles here
  task wait_flag(input logic [15:0] m);
    int n;
    n = 0;
    while ((st & m) !== m && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(st & m, m);
  endtask : wait_flag
  task clear(input logic [15:0] m);
    @(posedge clk);
    clr <= m;
    @(posedge clk);
    clr <= 16'h0000;
    @(posedge clk);
    #1;
  endtask : clear
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report;
    end
  end
  initial begin
    {rst_n, trig, start_request, stop_request, txw, ack_en, hold_low} = 7'h00;
    mode = 3'h0;
    sel = 2'h0;
    txd = 8'h00;
    ien = 16'h00F7;
    clr = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({st[15:3], irq, scl_oe, sda_oe}, 16'h0000);
    // engine must stay off with a nonzero sample select
    @(posedge clk);
    mode <= 3'h4;
    sel <= 2'h1;
    repeat (5) @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    check(16'(pend), 16'h0000);
    @(posedge clk);
    sel <= 2'h0;
    repeat (10) @(posedge clk);
    command(1'b1, 1'b0);
    wait_flag(16'h0100);
    repeat (3) @(posedge clk);
    #1;
    check(16'(irq), 16'h0001);
    repeat (20) @(posedge clk);
    #1;
    check(16'(scl_oe), 16'h0001);
    clear(16'h0100);
    check(st, 16'h0000);
    ack_en <= 1'b1;
    load(8'hA0);
    command(1'b0, 1'b0);
    wait_flag(16'h2000);
    check(16'(rx), 16'h00A0);
    // no trigger yet: clock must stay held after the acknowledge
    repeat (12) @(posedge clk);
    #1;
    check(16'(scl_oe), 16'h0001);
    clear(16'h2000);
    ack_en <= 1'b0;
    load(8'h5A);
    command(1'b0, 1'b0);
    wait_flag(16'h0400);
    // no new byte after a refusal: clock stays held, no new flag
    command(1'b0, 1'b0);
    repeat (200) @(posedge clk);
    #1;
    check(st, 16'h0400);
    check(16'(scl_oe), 16'h0001);
    clear(16'h0400);
    command(1'b0, 1'b1);
    wait_flag(16'h0200);
    check({14'h0000, scl_bus, sda_bus}, 16'h0003);
    clear(16'h0200);
    // another master wins while this one sends all ones
    command(1'b1, 1'b0);
    wait_flag(16'h0100);
    clear(16'h0100);
    hold_low <= 1'b1;
    load(8'hFF);
    command(1'b0, 1'b0);
    wait_flag(16'h0800);
    repeat (40) @(posedge clk);
    #1;
    check(16'(irq), 16'h0001);
    check({14'h0000, scl_oe, sda_oe}, 16'h0000);
    ien <= 16'h00E7;
    repeat (3) @(posedge clk);
    #1;
    check(16'(irq), 16'h0000);
    // winner lets data rise with clock high, a stop; then a fresh frame
    hold_low <= 1'b0;
    clear(16'h0800);
    command(1'b1, 1'b0);
    wait_flag(16'h0100);
    final_report;
  end
endmodule : i2c_protocol_engine_bench
`default_nettype wire
